// ==== design/stc_timer.sv ====
// Sixteen-bit timer/counter with prescaler, crystal oscillator and APB registers.
// Assumes pins are synchronous to pclk, pclk is the oscillator clock and presetn is power-on/brown-out.
//
// Function
// - Source select clear: count instruction cycles through the prescaler; sync disable ignored.
// - Source select set: count crystal input edges if oscillator on, else external pin.
// - Synchronized mode: input passes a prescaler first, then gets synchronized to phases.
// - Prescaler output sampled in Q2 and Q4; increment follows after a delay.
// - Synchronized counting in sleep freezes count while the prescaler keeps counting.
// - Sync disable set: count prescaled clock directly, runs in sleep, overflow wakes.
// - Reading either count byte while running gives a valid value.
// - Oscillator enable starts the crystal oscillator; it keeps running in sleep.
// - Compare special event match clears the count at its next clock edge.
// - A special event clear never sets the overflow flag.
// - Special event clear works only in internal or synchronized counting.
// - A count write in the same cycle as a special event clear wins for the byte written; the other byte clears.
// - No reset clears the count bytes; only the special event does.
// - Power-on reset clears control; counter stops with 1:1 prescale.
// - Any write to either count byte clears the prescaler.
// - Count wraps from maximum to zero and sets the overflow flag.
// - Counter advances only while counter on is set.
// - Overflow interrupt enable gates the overflow flag onto the request.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module stc_timer (
   input  wire  logic                  pclk,
   input  wire  logic                  presetn,
   input  wire  logic                  clk_en,
   input  wire  logic                  psel,
   input  wire  logic                  penable,
   input  wire  logic                  pwrite,
   input  wire  logic [7:0]            paddr,
   input  wire  logic [31:0]           pwdata,
   output logic       [31:0]           prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire  logic                  ext_clock_pin,
   input  wire  logic                  crystal_in_pin,
   output logic                        crystal_out_pin,
   output logic                        osc_running,
   input  wire  logic                  sleep_mode,
   input  wire  stc_pkg::stc_compare_t compare_in,
   output logic                        overflow_irq,
   output logic                        wake_request,
   output logic       [15:0]           count_value
);
   import stc_pkg::*;

   stc_control_t control;
   stc_phase_t   phase;
   stc_phase_t   next_phase;
   logic [15:0]  count;
   logic [15:0]  next_count;
   logic [2:0]   presc_cnt;
   logic [2:0]   presc_mask;
   logic         overflow_flag;
   logic         overflow_int_enable;
   logic         ext_sel;
   logic         ext_prev;
   logic         ext_rise;
   logic         inst_tick;
   logic         raw_tick;
   logic         presc_tick;
   logic         presc_out;
   logic         sync_samp;
   logic         sync_prev;
   logic         sync_pend;
   logic         async_mode;
   logic         count_tick;
   logic         clear_now;
   logic         wrap_now;
   logic         acc;
   logic         wr;
   logic         wr_low;
   logic         wr_high;
   logic         cnt_wr;
   logic         flag_wr_clr;
   logic         addr_hit;
   logic [7:0]   read_byte;

   // APB decode; every access completes in its first access cycle.
   assign acc         = psel && penable;
   assign wr          = acc && pwrite && clk_en;
   assign wr_low      = wr && (paddr == ADDR_COUNT_LOW);
   assign wr_high     = wr && (paddr == ADDR_COUNT_HIGH);
   assign cnt_wr      = wr_low || wr_high;
   assign flag_wr_clr = wr && (paddr == ADDR_FLAGS) && !pwdata[FLAG_OVF_POS];
   assign addr_hit    = (paddr == ADDR_COUNT_LOW) || (paddr == ADDR_COUNT_HIGH) ||
                        (paddr == ADDR_CONTROL) || (paddr == ADDR_FLAGS) || (paddr == ADDR_ENABLES);
   assign pready      = 1'b1;
   assign pslverr     = acc && !addr_hit;

   always_comb begin
      read_byte = 8'h00;
      case (paddr)
         ADDR_COUNT_LOW:  read_byte = count[7:0];
         ADDR_COUNT_HIGH: read_byte = count[15:8];
         ADDR_CONTROL:    read_byte = control & CONTROL_MASK;
         ADDR_FLAGS:      read_byte = {7'h00, overflow_flag};
         ADDR_ENABLES:    read_byte = {7'h00, overflow_int_enable};
         default:         read_byte = 8'h00;
      endcase
   end

   // Read data is captured in the setup cycle, so a byte never changes while the master samples it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (clk_en && psel && !penable) begin
         prdata <= {24'h000000, read_byte};
      end
   end

   // Only power-on or brown-out reset reaches the control register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= CONTROL_RESET;
      end else if (wr && (paddr == ADDR_CONTROL)) begin
         control <= pwdata[7:0] & CONTROL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_int_enable <= 1'b0;
      end else if (wr && (paddr == ADDR_ENABLES)) begin
         overflow_int_enable <= pwdata[EN_OVF_POS];
      end
   end

   // Phase clocks run only while awake; the phase holds in sleep while the oscillator clock keeps running.
   always_comb begin
      case (phase)
         PH_Q1:   next_phase = PH_Q2;
         PH_Q2:   next_phase = PH_Q3;
         PH_Q3:   next_phase = PH_Q4;
         PH_Q4:   next_phase = PH_Q1;
         default: next_phase = PH_Q1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= PH_Q1;
      end else if (clk_en && !sleep_mode) begin
         phase <= next_phase;
      end
   end

   // Crystal amplifier: an inverter across the pins, switched off with the enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_out_pin <= 1'b0;
      end else if (clk_en) begin
         crystal_out_pin <= control.crystal_osc_enable && !crystal_in_pin;
      end
   end

   assign osc_running = control.crystal_osc_enable;

   // Source selection and edge detection on the chosen input.
   assign ext_sel   = control.crystal_osc_enable ? crystal_in_pin : ext_clock_pin;
   assign ext_rise  = ext_sel && !ext_prev;
   assign inst_tick = (phase == PH_Q4) && !sleep_mode;
   assign raw_tick  = control.clock_source_select ? ext_rise : inst_tick;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev <= 1'b0;
      end else if (clk_en) begin
         ext_prev <= ext_sel;
      end
   end

   // Prescaler; ratio 2^n for select code n.
   always_comb begin
      case (control.input_prescale_select)
         2'b00:   presc_mask = 3'h0;
         2'b01:   presc_mask = 3'h1;
         2'b10:   presc_mask = 3'h3;
         2'b11:   presc_mask = 3'h7;
         default: presc_mask = 3'h0;
      endcase
   end

   assign presc_tick = raw_tick && ((presc_cnt & presc_mask) == presc_mask);

   // The prescaler keeps counting edges in sleep; writes to the count restart it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_cnt <= PRESC_ZERO;
      end else if (clk_en) begin
         if (cnt_wr) begin
            presc_cnt <= PRESC_ZERO;
         end else if (control.counter_on && raw_tick) begin
            presc_cnt <= presc_cnt + 3'h1;
         end
      end
   end

   // Prescaler output level as seen by the synchronizer.
   always_comb begin
      case (control.input_prescale_select)
         2'b00:   presc_out = ext_sel;
         2'b01:   presc_out = presc_cnt[0];
         2'b10:   presc_out = presc_cnt[1];
         2'b11:   presc_out = presc_cnt[2];
         default: presc_out = ext_sel;
      endcase
   end

   // Synchronizer samples on Q2 and Q4 only and is powered down in sleep.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_samp <= 1'b0;
         sync_prev <= 1'b0;
         sync_pend <= 1'b0;
      end else if (clk_en && !sleep_mode) begin
         if ((phase == PH_Q2) || (phase == PH_Q4)) begin
            sync_samp <= presc_out;
            sync_prev <= sync_samp;
         end
         // One cycle of delay between the synchronized edge and the increment.
         sync_pend <= ((phase == PH_Q1) || (phase == PH_Q3)) && sync_samp && !sync_prev;
      end
   end

   assign async_mode = control.clock_source_select && control.sync_disable;

   always_comb begin
      count_tick = 1'b0;
      if (control.counter_on) begin
         if (!control.clock_source_select) begin
            count_tick = presc_tick;
         end else if (control.sync_disable) begin
            count_tick = presc_tick;
         end else begin
            count_tick = sync_pend && !sleep_mode;
         end
      end
   end

   // The trigger is not honoured in unsynchronized counting, where the compare result is unsafe.
   assign clear_now = count_tick && !async_mode &&
                      (compare_in.compare_mode_field == MODE_SPECIAL_EVT) &&
                      (count == compare_in.compare_value_pair);
   assign wrap_now  = count_tick && !clear_now && (count == COUNT_MAX) && !cnt_wr;

   always_comb begin
      next_count = count;
      if (clear_now) begin
         next_count = COUNT_ZERO;
      end else if (count_tick) begin
         next_count = count + 16'h0001;
      end
      // A write collides with an increment by overwriting its byte.
      if (wr_low) begin
         next_count[7:0] = pwdata[7:0];
      end
      if (wr_high) begin
         next_count[15:8] = pwdata[7:0];
      end
   end

   // The count has no reset at all; it starts unknown until written or cleared.
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         count <= next_count;
      end
   end

   assign count_value = count;

   // Software clears the flag by writing zero; a wrap in the same cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
      end else if (clk_en) begin
         if (wrap_now) begin
            overflow_flag <= 1'b1;
         end else if (flag_wr_clr) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   assign overflow_irq = overflow_flag && overflow_int_enable;
   assign wake_request = overflow_irq && sleep_mode;

   int_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
      (count_tick && !control.clock_source_select) |-> (phase == PH_Q4) && !sleep_mode)
      else $error("internal count tick outside Q4");

   src_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(clk_en) && ext_rise) |->
         (control.crystal_osc_enable ? (crystal_in_pin && !$past(crystal_in_pin)) :
                                       (ext_clock_pin && !$past(ext_clock_pin))))
      else $error("edge taken from wrong source pin");

   sync_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (phase != PH_Q2 && phase != PH_Q4) |=> $stable(sync_samp))
      else $error("synchronizer sampled outside Q2 and Q4");

   sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_pend |-> $past(sync_samp) && !$past(sync_prev))
      else $error("sync increment without sampled edge");

   sleep_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sleep_mode && control.clock_source_select && !control.sync_disable && !cnt_wr) |=> $stable(count))
      else $error("synchronized count moved during sleep");

   async_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && async_mode && control.counter_on && presc_tick && !cnt_wr && count != COUNT_MAX)
      |=> count == $past(count) + 16'h0001)
      else $error("asynchronous count did not advance");

   trig_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && clear_now && !cnt_wr) |=> count == COUNT_ZERO)
      else $error("special event did not clear count");

   trig_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && clear_now && !overflow_flag) |=> !overflow_flag)
      else $error("special event set overflow flag");

   write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_low && !wr_high) |=> count[7:0] == $past(pwdata[7:0]))
      else $error("count write lost");

   presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_wr |=> presc_cnt == PRESC_ZERO)
      else $error("prescaler not cleared by count write");

   wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && wrap_now) |=> (count == COUNT_ZERO) && overflow_flag)
      else $error("wrap did not zero count and set flag");

   off_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!control.counter_on && !cnt_wr) |=> $stable(count))
      else $error("count moved while stopped");

   irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      overflow_irq == (overflow_flag && overflow_int_enable))
      else $error("interrupt request not gated by enable");

endmodule : stc_timer

// ==== pkg/stc_pkg.sv ====
// Constants, register map and types of the sixteen-bit timer/counter.
// Assumes an APB master with 32-bit data and an 8-bit byte address.
package stc_pkg;

   // Printed offsets are register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_COUNT_LOW    = 8'h0E;
   localparam logic [7:0] IDX_COUNT_HIGH   = 8'h0F;
   localparam logic [7:0] IDX_CONTROL      = 8'h10;
   localparam logic [7:0] IDX_FLAGS        = 8'h11;
   localparam logic [7:0] IDX_ENABLES      = 8'h12;

   localparam logic [7:0] ADDR_COUNT_LOW   = 8'(IDX_COUNT_LOW * 4);
   localparam logic [7:0] ADDR_COUNT_HIGH  = 8'(IDX_COUNT_HIGH * 4);
   localparam logic [7:0] ADDR_CONTROL     = 8'(IDX_CONTROL * 4);
   localparam logic [7:0] ADDR_FLAGS       = 8'(IDX_FLAGS * 4);
   localparam logic [7:0] ADDR_ENABLES     = 8'(IDX_ENABLES * 4);

   // Field positions inside the control, flag and enable registers.
   localparam int         CTL_ON_POS       = 0;
   localparam int         CTL_SRC_POS      = 1;
   localparam int         CTL_SYNC_POS     = 2;
   localparam int         CTL_OSC_POS      = 3;
   localparam int         CTL_PS_POS       = 4;
   localparam int         FLAG_OVF_POS     = 0;
   localparam int         EN_OVF_POS       = 0;

   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam logic [7:0] CONTROL_MASK     = 8'h3F;
   localparam logic [3:0] MODE_SPECIAL_EVT = 4'hB;
   localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO      = 16'h0000;
   localparam logic [2:0] PRESC_ZERO       = 3'h0;

   // Control register as stored; the two upper bits are reserved and read as zero.
   typedef struct packed {
      logic [1:0] reserved;
      logic [1:0] input_prescale_select;
      logic       crystal_osc_enable;
      logic       sync_disable;
      logic       clock_source_select;
      logic       counter_on;
   } stc_control_t;

   // Compare unit inputs travel together.
   typedef struct packed {
      logic [3:0]  compare_mode_field;
      logic [15:0] compare_value_pair;
   } stc_compare_t;

   // Internal phase clocks; one instruction cycle is four input clocks.
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } stc_phase_t;

endpackage : stc_pkg

// ==== dv/stc_clk_src.sv ====
// Partner model: an external clock source that feeds either the external pin or the crystal input.
// Assumes it is clocked by pclk and started by a one-cycle go pulse from the bench.
`timescale 1ns/1ps

module stc_clk_src (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       go,
   input  wire logic       use_xtal,
   input  wire logic [7:0] n_pulses,
   output logic            ext_clock_pin,
   output logic            crystal_in_pin,
   output logic            busy
);
   logic [7:0] left;
   logic [2:0] half;
   logic       lvl;
   logic       xsel;

   // Eight cycles per half period keeps each level well clear of the two-phase sampling window.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left <= 8'h00;
         half <= 3'h0;
         lvl  <= 1'b0;
         xsel <= 1'b0;
      end else if (go && left == 8'h00) begin
         left <= n_pulses;
         xsel <= use_xtal;
         half <= 3'h0;
      end else if (left != 8'h00) begin
         half <= half + 3'h1;
         if (half == 3'h7) begin
            lvl <= ~lvl;
            if (lvl) begin
               left <= left - 8'h01;
            end
         end
      end
   end

   // The source stands still low between bursts, so no stray edge reaches the counter.
   assign ext_clock_pin  = lvl & ~xsel;
   assign crystal_in_pin = lvl & xsel;
   assign busy           = (left != 8'h00);
endmodule : stc_clk_src

// ==== dv/sixteen_bit_timer_counter_tb_top.sv ====
// Testbench for the timer/counter: registers, every count source, sleep, overflow, special event, reset.
// Assumes a zero-wait APB slave and the clock source partner model.
`timescale 1ns/1ps

module sixteen_bit_timer_counter_tb_top;
   import stc_pkg::*;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic        xtal;
      logic [7:0]  n;
      logic [15:0] lo;
      logic [15:0] hi;
   } stc_row_t;

   logic         pclk = 1'b0;
   logic         presetn = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic         sleep_mode = 1'b0;
   logic         clk_en = 1'b1;
   stc_compare_t cmp = '0;
   logic         go = 1'b0;
   logic         use_xtal = 1'b0;
   logic [7:0]   n_pulses = 8'h00;
   logic [31:0]  prdata, r;
   logic         pready, pslverr, perr, crystal_out_pin, osc_running, overflow_irq, wake_request;
   logic         ext_clock_pin, crystal_in_pin, busy;
   logic [15:0]  count_value, c, mx;
   int           err_total = 0;
   int           checks_done = 0;

   // Internal rows run 4*n cycles; external rows send n pulses. Off, wrong-pin and prescaled cases included.
   stc_row_t rows [12] = '{
      '{8'h01, 1'b0, 8'd8,  16'd7,  16'd9},  '{8'h11, 1'b0, 8'd16, 16'd7,  16'd9},
      '{8'h21, 1'b0, 8'd32, 16'd7,  16'd9},  '{8'h35, 1'b0, 8'd64, 16'd7,  16'd9},
      '{8'h03, 1'b0, 8'd10, 16'd10, 16'd10}, '{8'h13, 1'b0, 8'd16, 16'd7,  16'd8},
      '{8'h0B, 1'b1, 8'd10, 16'd10, 16'd10}, '{8'h07, 1'b0, 8'd10, 16'd10, 16'd10},
      '{8'h27, 1'b0, 8'd16, 16'd3,  16'd4},  '{8'h0F, 1'b1, 8'd5,  16'd5,  16'd5},
      '{8'h03, 1'b1, 8'd10, 16'd0,  16'd0},  '{8'h02, 1'b0, 8'd10, 16'd0,  16'd0}};

   always #2 pclk = ~pclk;

   stc_timer DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clock_pin(ext_clock_pin), .crystal_in_pin(crystal_in_pin), .crystal_out_pin(crystal_out_pin),
      .osc_running(osc_running), .sleep_mode(sleep_mode), .compare_in(cmp), .overflow_irq(overflow_irq),
      .wake_request(wake_request), .count_value(count_value));

   stc_clk_src src (.pclk(pclk), .presetn(presetn), .go(go), .use_xtal(use_xtal), .n_pulses(n_pulses),
      .ext_clock_pin(ext_clock_pin), .crystal_in_pin(crystal_in_pin), .busy(busy));

   task automatic end_of_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checks_done++;
      if ((got < lo) !== 1'b0 || (got > hi) !== 1'b0) begin
         err_total++;
         $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rv);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] dummy;
      apb(1'b1, a, d, dummy);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] rv);
      apb(1'b0, a, 8'h00, rv);
   endtask : rd

   // High, low, high again; a changed high byte means a carry slipped between the reads.
   task automatic rdcnt(output logic [15:0] cv);
      logic [31:0] h1, l, h2;
      rd(ADDR_COUNT_HIGH, h1);
      rd(ADDR_COUNT_LOW, l);
      rd(ADDR_COUNT_HIGH, h2);
      if (h1 !== h2) begin
         rd(ADDR_COUNT_HIGH, h2);
         rd(ADDR_COUNT_LOW, l);
      end
      cv = {h2[7:0], l[7:0]};
   endtask : rdcnt

   task automatic setcnt(input logic [15:0] v);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_COUNT_LOW, v[7:0]);
      wr(ADDR_COUNT_HIGH, v[15:8]);
   endtask : setcnt

   task automatic burst(input logic x, input logic [7:0] n);
      @(posedge pclk);
      use_xtal <= x;
      n_pulses <= n;
      go       <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      do begin
         @(posedge pclk);
      end while (busy !== 1'b0);
      repeat (20) @(posedge pclk);
   endtask : burst

   initial begin
      #100000;
      err_total++;
      end_of_test();
   end

   initial begin
      // The count has no reset, so it is loaded under reset to keep the checkers free of unknowns.
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      repeat (14) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CONTROL, r);
      chk(r, 32'h0, 32'h0);
      chk({30'h0, osc_running, crystal_out_pin}, 32'h0, 32'h0);
      rd(ADDR_FLAGS, r);
      chk(r, 32'h0, 32'h0);
      rd(8'h00, r);
      chk({31'h0, perr}, 32'h1, 32'h1);
      wr(ADDR_CONTROL, 8'hFF);
      rd(ADDR_CONTROL, r);
      chk(r, 32'h3F, 32'h3F);
      chk({30'h0, osc_running, crystal_out_pin}, 32'h3, 32'h3);
      // With the clock enable low a register write must be ignored.
      clk_en <= 1'b0;
      wr(ADDR_CONTROL, 8'h00);
      clk_en <= 1'b1;
      rd(ADDR_CONTROL, r);
      chk(r, 32'h3F, 32'h3F);
      foreach (rows[i]) begin
         setcnt(16'h0000);
         wr(ADDR_CONTROL, rows[i].ctrl);
         if (rows[i].ctrl[CTL_OSC_POS]) repeat (8) @(posedge pclk);
         if (rows[i].ctrl[CTL_SRC_POS]) burst(rows[i].xtal, rows[i].n);
         else repeat (4 * int'(rows[i].n)) @(posedge pclk);
         wr(ADDR_CONTROL, 8'h00);
         rdcnt(c);
         chk({16'h0, c}, {16'h0, rows[i].lo}, {16'h0, rows[i].hi});
      end
      setcnt(16'h0000);
      wr(ADDR_CONTROL, 8'h03);
      sleep_mode <= 1'b1;
      burst(1'b0, 8'd10);
      sleep_mode <= 1'b0;
      rdcnt(c);
      chk({16'h0, c}, 32'h0, 32'h0);
      setcnt(16'hFFFE);
      wr(ADDR_ENABLES, 8'h00);
      wr(ADDR_CONTROL, 8'h07);
      sleep_mode <= 1'b1;
      burst(1'b0, 8'd3);
      rdcnt(c);
      chk({16'h0, c}, 32'h1, 32'h1);
      chk({31'h0, overflow_irq}, 32'h0, 32'h0);
      rd(ADDR_FLAGS, r);
      chk(r, 32'h1, 32'h1);
      wr(ADDR_ENABLES, 8'h01);
      @(posedge pclk);
      chk({31'h0, overflow_irq}, 32'h1, 32'h1);
      chk({31'h0, wake_request}, 32'h1, 32'h1);
      sleep_mode <= 1'b0;
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, r);
      chk(r, 32'h0, 32'h0);
      setcnt(16'h0000);
      cmp <= '{MODE_SPECIAL_EVT, 16'h0005};
      wr(ADDR_CONTROL, 8'h01);
      mx = 16'h0000;
      repeat (200) begin
         @(posedge pclk);
         if (count_value > mx) mx = count_value;
      end
      chk({16'h0, mx}, 32'h5, 32'h5);
      // A match at the top of the range must clear the count without the wrap setting the flag.
      setcnt(16'hFFFD);
      cmp <= '{MODE_SPECIAL_EVT, COUNT_MAX};
      wr(ADDR_CONTROL, 8'h01);
      repeat (40) @(posedge pclk);
      wr(ADDR_CONTROL, 8'h00);
      cmp <= '0;
      rd(ADDR_FLAGS, r);
      chk(r, 32'h0, 32'h0);
      setcnt(16'h1234);
      wr(ADDR_CONTROL, 8'h30);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CONTROL, r);
      chk(r, 32'h0, 32'h0);
      rdcnt(c);
      chk({16'h0, c}, 32'h1234, 32'h1234);
      end_of_test();
   end
endmodule : sixteen_bit_timer_counter_tb_top
